// *** verilog/clkmux_defs.svh ***
`ifndef CLKMUX_DEFS_SVH
`define CLKMUX_DEFS_SVH

// Register indices on the serial bus
`define IDX_MODE 8'h00
`define IDX_GATE_LO 8'h01
`define IDX_GATE_HI 8'h02
`define IDX_SWING 8'h03
`define IDX_SPARE 8'h04
`define IDX_IDENT 8'h05
`define IDX_PART 8'h06
`define IDX_LENGTH 8'h07
`define IDX_SPARE8 8'h08

// Mode byte field positions
`define MODE_SW_EN_BIT 3
`define MODE_PLL_HI_BIT 2
`define MODE_PLL_LO_BIT 1
`define MODE_SEL_BIT 0

// Reset values and the reserved swing code
`define MODE_CTL_RST 4'h7
`define GATE_RST 12'hFFF
`define SWING_RST 3'h4
`define SWING_RSVD 3'h7
`define LENGTH_RST 5'h08

// Timing counts
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7
`define STRAP_DLY 2'h3

`endif

// *** verilog/clkmux_pkg.sv ***
package clkmux_pkg;

	// Serial bus slave states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_RX = 6'h04,
		ST_ACK = 6'h08,
		ST_TX = 6'h10,
		ST_RACK = 6'h20
	} bus_state_t;

	// Meaning of the next received byte of a write
	typedef enum logic [2:0] {
		PH_INDEX = 3'h1,
		PH_COUNT = 3'h2,
		PH_DATA = 3'h4
	} wr_phase_t;

	// Strap pins sampled once after reset
	typedef struct packed {
		logic [1:0] loop_mode;
		logic input_sel;
	} strap_pins_t;

	// Controls driven into the clock datapath
	typedef struct packed {
		logic [11:0] pair_run;
		logic [2:0] swing;
		logic [1:0] loop_mode;
		logic input_sel;
	} ctrl_out_t;

	// Whole state of the register bank
	typedef struct packed {
		bus_state_t st;
		wr_phase_t phase;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic rd;
		logic host_ack;
		logic [7:0] ptr;
		logic [7:0] remain;
		logic sda_oe;
		logic scl_q;
		logic sda_q;
		logic latched;
		logic [1:0] latch_dly;
		logic [1:0] strap_mode;
		logic strap_sel;
		logic [3:0] mode_ctl;
		logic [11:0] gate;
		logic [2:0] swing;
		logic [4:0] length;
		ctrl_out_t ctrl;
	} regbank_state_t;

endpackage : clkmux_pkg

// *** verilog/pin_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;

	// Two stages; the first is read only by the second
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			meta <= '0;
			o_sync <= '0;
		end else if (i_clk_en) begin
			meta <= i_async;
			o_sync <= meta;
		end
	end

endmodule : pin_sync2

`default_nettype wire

// *** verilog/clock_mux_smbus_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "clkmux_defs.svh"

// Notes on behaviour
// R1: Override bit 3 set makes mode byte bits 2:0 drive loop mode and input.
// R2: Mode byte bits 7:5 always read the strap values latched after reset.
// R3: Index 1 bits gate pairs 7..0; a zero forces the pair off.
// R4: Index 2 bits 3:0 gate pairs 11..8, default one; bits 7:4 read zero.
// R5: Three-bit swing code at index 3, default 100, code 111 reserved.
// R6: Index 5 holds revision and maker codes, index 6 part code; read-only.
// R7: Index 7 bits 4:0 hold the block read length.
// R8: Length resets to 8, a default block read covering indices 0 to 7.
// R9: Index 4 is all reserved and reads zero.
// R10: Block read sends the length first, then bytes from the index on.
// R11: Host writes index, count, then data; each byte is acknowledged.
// R12: Override bit resets to zero so straps govern until software sets it.
// R13: Writes to reserved or read-only bits are acknowledged and dropped.

module clock_mux_smbus_control_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h6A, // Value is arbitrary
	parameter logic [3:0] REV_CODE = 4'h3, // Value is arbitrary
	parameter logic [3:0] MAKER_CODE = 4'h5, // Value is arbitrary
	parameter logic [7:0] PART_CODE = 8'h5A // Value is arbitrary
) (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Serial bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// Strap and enable pins
	input wire clkmux_pkg::strap_pins_t i_strap,
	input wire logic [11:0] i_pair_off_n,
	// Datapath controls
	output clkmux_pkg::ctrl_out_t o_ctrl
);
	import clkmux_pkg::*;

	localparam regbank_state_t RST_STATE = '{
		st: ST_IDLE,
		phase: PH_INDEX,
		mode_ctl: `MODE_CTL_RST, // [R12]
		gate: `GATE_RST,
		swing: `SWING_RST,
		length: `LENGTH_RST, // [R8]
		default: '0
	};

	regbank_state_t s;
	regbank_state_t next_s;
	logic [1:0] bus_sync;
	logic [14:0] pin_sync;
	strap_pins_t strap_now;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic wr_en;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;

	// Bus pins and board pins come from outside the clock domain
	pin_sync2 #(.WIDTH(2)) u_bus_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_async({i_scl, i_sda}),
		.o_sync(bus_sync)
	);

	pin_sync2 #(.WIDTH(15)) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_async({i_strap, i_pair_off_n}),
		.o_sync(pin_sync)
	);

	// Bus events from synchronised levels against last cycle
	assign strap_now = strap_pins_t'(pin_sync[14:12]);
	assign scl = bus_sync[1];
	assign sda = bus_sync[0];
	assign scl_rise = scl & ~s.scl_q;
	assign scl_fall = ~scl & s.scl_q;
	assign start_det = scl & s.scl_q & s.sda_q & ~sda;
	assign stop_det = scl & s.scl_q & ~s.sda_q & sda;

	// Read mux; unmapped indices return zero
	function automatic logic [7:0] read_byte(input regbank_state_t r,
			input logic [7:0] idx);
		case (idx)
			`IDX_MODE: read_byte = {r.strap_mode, r.strap_sel, 1'b0,
				r.mode_ctl}; // [R2]
			`IDX_GATE_LO: read_byte = r.gate[7:0];
			`IDX_GATE_HI: read_byte = {4'h0, r.gate[11:8]}; // [R4]
			`IDX_SWING: read_byte = {5'h00, r.swing};
			`IDX_SPARE: read_byte = 8'h00; // [R9]
			`IDX_IDENT: read_byte = {REV_CODE, MAKER_CODE}; // [R6]
			`IDX_PART: read_byte = PART_CODE; // [R6]
			`IDX_LENGTH: read_byte = {3'h0, r.length}; // [R7]
			default: read_byte = 8'h00; // [R13]
		endcase
	endfunction : read_byte

	// Next state of the whole bank
	always_comb begin
		next_s = s;
		wr_en = 1'b0;
		wr_idx = s.ptr;
		wr_data = s.shift;
		next_s.scl_q = scl;
		next_s.sda_q = sda;

		// Straps settle through the synchroniser before being caught
		if (!s.latched) begin
			if (s.latch_dly == `STRAP_DLY) begin
				next_s.latched = 1'b1;
				next_s.strap_mode = strap_now.loop_mode; // [R2]
				next_s.strap_sel = strap_now.input_sel; // [R2]
			end else begin
				next_s.latch_dly = s.latch_dly + 2'h1;
			end
		end

		case (s.st)
			ST_IDLE: begin
				next_s.sda_oe = 1'b0;
			end
			ST_ADDR, ST_RX: begin
				if (scl_rise && s.bitcnt != `BITS_PER_BYTE) begin
					next_s.shift = {s.shift[6:0], sda};
					next_s.bitcnt = s.bitcnt + 4'h1;
				end else if (scl_fall && s.bitcnt == `BITS_PER_BYTE) begin
					if (s.st == ST_ADDR) begin
						if (s.shift[7:1] == DEV_ADDR) begin
							next_s.rd = s.shift[0];
							next_s.sda_oe = 1'b1;
							next_s.st = ST_ACK;
						end else begin
							next_s.st = ST_IDLE;
						end
					end else begin
						next_s.sda_oe = 1'b1; // [R11]
						next_s.st = ST_ACK;
						case (s.phase)
							PH_INDEX: begin
								next_s.ptr = s.shift;
								next_s.phase = PH_COUNT;
							end
							PH_COUNT: begin
								next_s.remain = s.shift;
								next_s.phase = PH_DATA;
							end
							PH_DATA: begin
								// Bytes past the count are acknowledged only
								if (s.remain != 8'h00) begin
									wr_en = 1'b1;
									next_s.ptr = s.ptr + 8'h01;
									next_s.remain = s.remain - 8'h01;
								end
							end
							default: begin
								next_s.phase = PH_INDEX;
							end
						endcase
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					next_s.bitcnt = 4'h0;
					if (s.rd) begin
						next_s.st = ST_TX;
						next_s.shift = {3'h0, s.length}; // [R10]
						next_s.sda_oe = ~next_s.shift[7];
					end else begin
						next_s.st = ST_RX;
						next_s.sda_oe = 1'b0;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (s.bitcnt == `LAST_TX_BIT) begin
						next_s.sda_oe = 1'b0;
						next_s.bitcnt = 4'h0;
						next_s.st = ST_RACK;
					end else begin
						next_s.bitcnt = s.bitcnt + 4'h1;
						next_s.shift = {s.shift[6:0], 1'b0};
						next_s.sda_oe = ~s.shift[6];
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					next_s.host_ack = ~sda;
				end else if (scl_fall) begin
					// A not-acknowledge ends the read
					if (s.host_ack) begin
						next_s.shift = read_byte(s, s.ptr); // [R10]
						next_s.ptr = s.ptr + 8'h01;
						next_s.sda_oe = ~next_s.shift[7];
						next_s.st = ST_TX;
					end else begin
						next_s.st = ST_IDLE;
					end
				end
			end
			default: begin
				next_s.st = ST_IDLE;
				next_s.sda_oe = 1'b0;
			end
		endcase

		// Start and stop win over any byte in progress
		if (start_det) begin
			next_s.st = ST_ADDR;
			next_s.bitcnt = 4'h0;
			next_s.sda_oe = 1'b0;
			next_s.phase = PH_INDEX;
		end else if (stop_det) begin
			next_s.st = ST_IDLE;
			next_s.sda_oe = 1'b0;
		end

		// Only writable fields take data; the rest is dropped silently
		if (wr_en) begin
			case (wr_idx)
				`IDX_MODE: next_s.mode_ctl = wr_data[3:0]; // [R1]
				`IDX_GATE_LO: next_s.gate[7:0] = wr_data; // [R3]
				`IDX_GATE_HI: next_s.gate[11:8] = wr_data[3:0]; // [R4]
				`IDX_SWING: begin
					// Reserved code keeps the previous swing
					if (wr_data[2:0] != `SWING_RSVD) begin
						next_s.swing = wr_data[2:0]; // [R5]
					end
				end
				`IDX_LENGTH: next_s.length = wr_data[4:0]; // [R7]
				default: begin
				end // [R13]
			endcase
		end

		// Registered controls; select polarity flips between the two sources
		next_s.ctrl.loop_mode = next_s.mode_ctl[`MODE_SW_EN_BIT] ?
			next_s.mode_ctl[`MODE_PLL_HI_BIT:`MODE_PLL_LO_BIT] :
			next_s.strap_mode; // [R1] [R12]
		next_s.ctrl.input_sel = next_s.mode_ctl[`MODE_SW_EN_BIT] ?
			~next_s.mode_ctl[`MODE_SEL_BIT] : next_s.strap_sel; // [R1]
		next_s.ctrl.pair_run = next_s.gate & ~pin_sync[11:0]; // [R3] [R4]
		next_s.ctrl.swing = next_s.swing;
	end

	// Reset acts regardless of the enable
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			s <= RST_STATE;
		end else if (i_clk_en) begin
			s <= next_s;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = s.sda_oe;
	assign o_ctrl = s.ctrl;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	// The controls register the value the mode byte takes on the same edge
	override_mux_a: assert property ( // [R1]
		i_clk_en && next_s.mode_ctl[3]
		|=> o_ctrl.loop_mode == s.mode_ctl[2:1]
			&& o_ctrl.input_sel == ~s.mode_ctl[0])
		else $error("override bits not driving loop mode");

	strap_hold_a: assert property ( // [R2]
		s.latched && $past(s.latched)
		|-> $stable({s.strap_mode, s.strap_sel}))
		else $error("strap readback changed after latch");

	gate_off_a: assert property ( // [R3]
		i_clk_en && wr_en && wr_idx == 8'h01 && wr_data[0] == 1'b0
		|=> o_ctrl.pair_run[0] == 1'b0)
		else $error("cleared gate bit left pair running");

	gate_high_rsvd_a: assert property ( // [R4]
		read_byte(s, 8'h02) <= 8'h0F)
		else $error("reserved gate bits read nonzero");

	// Controls are zero in reset, so the default shows one edge later
	swing_reset_a: assert property ( // [R5]
		$rose(i_rst_n) && i_clk_en |-> s.swing == 3'h4
		##1 o_ctrl.swing == 3'h4)
		else $error("swing default wrong");

	swing_rsvd_a: assert property ( // [R5]
		i_clk_en && wr_en && wr_idx == 8'h03 && wr_data[2:0] == 3'h7
		|=> s.swing == $past(s.swing))
		else $error("reserved swing code was stored");

	ident_fixed_a: assert property ( // [R6]
		i_clk_en && wr_en && (wr_idx == 8'h05 || wr_idx == 8'h06)
		|=> read_byte(s, 8'h05) == {REV_CODE, MAKER_CODE}
			&& read_byte(s, 8'h06) == PART_CODE)
		else $error("identity bytes changed by write");

	count_first_a: assert property ( // [R10]
		i_clk_en && s.st == ST_ACK && s.rd && scl_fall && !start_det
			&& !stop_det
		|=> s.st == ST_TX && s.shift == {3'h0, s.length})
		else $error("block read did not start with length");

	length_reset_a: assert property ( // [R8]
		$rose(i_rst_n) |-> read_byte(s, 8'h07) == 8'h08)
		else $error("length default wrong");

	spare_zero_a: assert property ( // [R9]
		read_byte(s, 8'h04) == 8'h00 && read_byte(s, 8'h08) == 8'h00)
		else $error("reserved byte reads nonzero");

	byte_ack_a: assert property ( // [R11]
		i_clk_en && s.st == ST_RX && scl_fall && s.bitcnt == 4'h8
			&& !start_det && !stop_det
		|=> s.st == ST_ACK && o_sda_oe)
		else $error("received byte not acknowledged");

	override_reset_a: assert property ( // [R12]
		$rose(i_rst_n) |-> s.mode_ctl[3] == 1'b0 && s.mode_ctl[2:0] == 3'h7)
		else $error("mode byte default wrong");

endmodule : clock_mux_smbus_control_regs

`default_nettype wire

// *** bench/smb_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module smb_host (
	// Clock and wire level
	input wire logic i_sys_clk,
	input wire logic i_sda_wire,
	// Host pins, open drain
	output logic o_scl,
	output logic o_sda
);
	localparam int HALF = 8; // Half bus period in system cycles, above 4

	// Bus idles high through the pull-ups
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// Pins only move at the falling system edge
	task automatic tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : tick

	// Data moves after SCL low has settled, never with it
	task automatic clk_bit(input logic b, output logic s);
		o_sda = b;
		tick(HALF);
		o_scl = 1'b1;
		tick(HALF);
		s = i_sda_wire;
		o_scl = 1'b0;
		tick(2);
	endtask : clk_bit

	// Start or repeated start
	task automatic start_bit();
		o_sda = 1'b1;
		tick(HALF);
		o_scl = 1'b1;
		tick(HALF);
		o_sda = 1'b0;
		tick(HALF);
		o_scl = 1'b0;
		tick(2);
	endtask : start_bit

	task automatic stop_bit();
		o_sda = 1'b0;
		tick(HALF);
		o_scl = 1'b1;
		tick(HALF);
		o_sda = 1'b1;
		tick(HALF);
	endtask : stop_bit

	// Byte out MSB first; ack is high when the device pulled bit nine low
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask : send

	// Byte in; last gives a not-acknowledge to end the read
	task automatic recv(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(last, s);
	endtask : recv
endmodule : smb_host

`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import clkmux_pkg::*;
	localparam logic [6:0] DEV = 7'h6A;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_clk_en = 1'b1;
	strap_pins_t i_strap = 3'h6;
	logic [11:0] i_pair_off_n = 12'h000;
	logic scl;
	logic sda_host;
	logic sda_oe;
	logic sda_out;
	logic sda_wire;
	ctrl_out_t ctrl;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [7:0] q [$];

	// Open drain wire: low if any party pulls
	assign sda_wire = sda_host & ~(sda_oe & ~sda_out);
	always #50 i_sys_clk = ~i_sys_clk;

	clock_mux_smbus_control_regs #(.DEV_ADDR(DEV)) dut (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
		.i_scl(scl), .i_sda(sda_wire), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .i_strap(i_strap),
		.i_pair_off_n(i_pair_off_n), .o_ctrl(ctrl));

	smb_host host (.i_sys_clk(i_sys_clk), .i_sda_wire(sda_wire),
		.o_scl(scl), .o_sda(sda_host));

	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic chk_ctrl(input ctrl_out_t e);
		samples_checked++;
		if (ctrl !== e) begin
			fails++;
			$display("mismatch o_ctrl expected %h seen %h", e, ctrl);
		end
	endtask : chk_ctrl

	task automatic chk_list(input string what, input logic [7:0] e [$]);
		foreach (e[i]) chk(what, e[i], q[i]);
	endtask : chk_list

	// Index, count, data, each byte answered
	task automatic wr(input logic [7:0] idx, input logic [7:0] d [$]);
		logic a;
		host.start_bit();
		host.send({DEV, 1'b0}, a);
		host.send(idx, a);
		host.send(8'(d.size()), a);
		chk("count ack", 8'h01, {7'h00, a});
		foreach (d[i]) begin
			host.send(d[i], a);
			chk("data ack", 8'h01, {7'h00, a});
		end
		host.stop_bit();
	endtask : wr

	// Length byte first, then n register bytes into q
	task automatic rd(input logic [7:0] idx, input int n);
		logic a;
		logic [7:0] b;
		q.delete();
		host.start_bit();
		host.send({DEV, 1'b0}, a);
		host.send(idx, a);
		host.start_bit();
		host.send({DEV, 1'b1}, a);
		chk("read ack", 8'h01, {7'h00, a});
		for (int i = 0; i <= n; i++) begin
			host.recv(i == n, b);
			q.push_back(b);
		end
		host.stop_bit();
	endtask : rd

	task automatic test_defaults();
		rd(8'h00, 9);
		chk_list("defaults", {8'h08, 8'hC7, 8'hFF, 8'h0F, 8'h04, 8'h00,
			8'h35, 8'h5A, 8'h08, 8'h00});
		chk_ctrl({12'hFFF, 3'h4, 2'h3, 1'h0});
		$display("test defaults done");
	endtask : test_defaults

	// Reserved bits and the reserved swing code must not land
	task automatic test_gates();
		wr(8'h01, {8'hA5, 8'hF3, 8'h07});
		chk_ctrl({12'h3A5, 3'h4, 2'h3, 1'h0});
		rd(8'h01, 3);
		chk_list("gates", {8'h08, 8'hA5, 8'h03, 8'h04});
		wr(8'h03, {8'h06});
		chk_ctrl({12'h3A5, 3'h6, 2'h3, 1'h0});
		@(negedge i_sys_clk);
		i_pair_off_n = 12'h004;
		host.tick(8);
		chk_ctrl({12'h3A1, 3'h6, 2'h3, 1'h0});
		i_pair_off_n = 12'h000;
		$display("test gates done");
	endtask : test_gates

	task automatic test_override();
		wr(8'h00, {8'hFA});
		chk_ctrl({12'h3A5, 3'h6, 2'h1, 1'h1});
		rd(8'h00, 1);
		chk_list("mode", {8'h08, 8'hCA});
		wr(8'h00, {8'h02});
		chk_ctrl({12'h3A5, 3'h6, 2'h3, 1'h0});
		$display("test override done");
	endtask : test_override

	// Low enable must hide a pin change until it returns high
	task automatic test_freeze();
		@(negedge i_sys_clk);
		i_clk_en = 1'b0;
		i_pair_off_n = 12'h001;
		host.tick(8);
		chk_ctrl({12'h3A5, 3'h6, 2'h3, 1'h0});
		i_clk_en = 1'b1;
		host.tick(8);
		chk_ctrl({12'h3A4, 3'h6, 2'h3, 1'h0});
		i_pair_off_n = 12'h000;
		host.tick(8);
		$display("test freeze done");
	endtask : test_freeze

	// Read-only and reserved bytes keep their values; length takes 4:0
	task automatic test_readonly();
		wr(8'h04, {8'hFF, 8'h00, 8'h00, 8'hE2});
		rd(8'h04, 5);
		chk_list("ro", {8'h02, 8'h00, 8'h35, 8'h5A, 8'h02, 8'h00});
		$display("test readonly done");
	endtask : test_readonly

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	// Main sequence: reset, let straps and syncs settle, then tests
	initial begin
		repeat (6) @(negedge i_sys_clk);
		i_rst_n = 1'b1;
		host.tick(20);
		test_defaults();
		test_gates();
		test_override();
		test_freeze();
		test_readonly();
		tally_and_finish();
	end

	// Hang guard, well above the expected 10200 cycles
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			tally_and_finish();
		end
	end
endmodule : tb_top

`default_nettype wire
